/* ocr_pkg.sv */
/*
 * Constants shared by the transceiver control register bank: byte
 * addresses, field positions and reset values.
 * Assumes byte-wide register access from the serial front end.
 */
package ocr_pkg;

   // ***************************************************************
   // Register byte addresses
   // ***************************************************************
   localparam logic [7:0] OCR_ADDR_MAKER_LO = 8'h00;
   localparam logic [7:0] OCR_ADDR_MAKER_HI = 8'h01;
   localparam logic [7:0] OCR_ADDR_PART_LO = 8'h02;
   localparam logic [7:0] OCR_ADDR_PART_HI = 8'h03;
   localparam logic [7:0] OCR_ADDR_CR1_SET = 8'h04;
   localparam logic [7:0] OCR_ADDR_CR1_CLR = 8'h05;
   localparam logic [7:0] OCR_ADDR_CR2_SET = 8'h06;
   localparam logic [7:0] OCR_ADDR_CR2_CLR = 8'h07;

   // ***************************************************************
   // Control register slots and field positions
   // ***************************************************************
   localparam int OCR_NUM_CTRL = 2;
   localparam int OCR_SLOT_LINE = 0;
   localparam int OCR_SLOT_PULL = 1;

   // Line control fields
   localparam int OCR_LINE_RATE_BIT = 0;
   localparam int OCR_LINE_POWER_BIT = 1;
   localparam int OCR_LINE_ENC_BIT = 2;

   // Pull and bus power fields
   localparam int OCR_PLUS_PULLUP_BIT = 0;
   localparam int OCR_MINUS_PULLUP_BIT = 1;
   localparam int OCR_PLUS_PULLDOWN_BIT = 2;
   localparam int OCR_MINUS_PULLDOWN_BIT = 3;
   localparam int OCR_ID_GROUND_BIT = 4;
   localparam int OCR_BUS_DRIVE_BIT = 5;
   localparam int OCR_BUS_DISCHARGE_BIT = 6;
   localparam int OCR_BUS_CHARGE_BIT = 7;

   // ***************************************************************
   // Reset and read values
   // ***************************************************************
   localparam logic [7:0] OCR_CTRL_RESET = 8'h00;
   localparam logic [7:0] OCR_READ_NONE = 8'h00;

endpackage : ocr_pkg

/* ocr_otg_phy_control_registers.sv */
/*
 * Control register bank of a USB on-the-go transceiver's serial
 * controller: identity words and two set/clear control registers.
 * Assumes the serial front end delivers one byte access per strobe,
 * synchronous to clk_sys_i, and never raises write and read together.
 */
// How it works
// - Writing ones to a set address sets those bits; line control set is 04h.
// - Writing ones to a clear address clears those bits; line control clear is 05h.
// - Reading the set or the clear address returns the same register contents.
// - Read-only 16-bit maker identity, low byte at 00h, high byte at 01h.
// - Read-only 16-bit part identity, low byte at 02h, high byte at 03h.
// - Line control bit 0 selects low speed (0) or full speed (1).
// - Line control bit 1 selects full power (0) or suspend (1).
// - Line control bit 2 selects split-line (0) or data plus SE0 (1) encoding.
// - Pull control bits 0..7: pull-ups, pull-downs, ID ground, bus drive, discharge, charge.
// - Reset clears register bits to zero unless a bit is preset to one.
`timescale 1ns/10ps
`default_nettype none

module ocr_otg_phy_control_registers
   import ocr_pkg::*;
#(
   parameter logic [15:0] MAKER_ID = 16'h1a2b, // Arbitrary value
   parameter logic [15:0] PART_ID = 16'h3c4d, // Arbitrary value
   parameter logic [7:0] LINE_RESET = OCR_CTRL_RESET,
   parameter logic [7:0] PULL_RESET = OCR_CTRL_RESET
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Byte register access from the serial front end
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Line control
   output logic line_rate_full_o,
   output logic line_suspend_o,
   output logic line_encoding_select_o,
   output logic [7:0] line_control_o,
   // Pull and bus power control
   output logic plus_line_pullup_o,
   output logic minus_line_pullup_o,
   output logic plus_line_pulldown_o,
   output logic minus_line_pulldown_o,
   output logic identification_pin_ground_o,
   output logic bus_power_drive_o,
   output logic bus_power_discharge_o,
   output logic bus_power_charge_o
);

   // ***************************************************************
   // Address decode
   // ***************************************************************
   localparam logic [7:0] CTRL_RESET_VAL [OCR_NUM_CTRL] = '{LINE_RESET, PULL_RESET};

   logic [7:0] ctrl_r [OCR_NUM_CTRL];
   logic [7:0] ctrl_ofs;
   logic ctrl_hit;
   logic ctrl_idx;
   logic ctrl_is_clear;
   logic [7:0] read_nxt;

   // Set and clear addresses pair up; bit 0 of the offset picks clear
   assign ctrl_ofs = reg_addr_i - OCR_ADDR_CR1_SET;
   assign ctrl_hit = (reg_addr_i >= OCR_ADDR_CR1_SET) && (reg_addr_i <= OCR_ADDR_CR2_CLR);
   assign ctrl_idx = ctrl_ofs[1];
   assign ctrl_is_clear = ctrl_ofs[0];

   // ***************************************************************
   // Control registers
   // ***************************************************************
   // One slot per control register; ones in the data act, zeros hold
   for (genvar g = 0; g < OCR_NUM_CTRL; g++) begin : g_ctrl
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            ctrl_r[g] <= CTRL_RESET_VAL[g];
         end else if (reg_wr_i && ctrl_hit && (int'(ctrl_idx) == g)) begin
            if (ctrl_is_clear) begin
               ctrl_r[g] <= ctrl_r[g] & ~reg_wdata_i;
            end else begin
               ctrl_r[g] <= ctrl_r[g] | reg_wdata_i;
            end
         end
      end
   end

   // ***************************************************************
   // Read path
   // ***************************************************************
   // Unmapped addresses read as zero rather than stale data
   always_comb begin
      read_nxt = OCR_READ_NONE;
      case (reg_addr_i)
         OCR_ADDR_MAKER_LO: read_nxt = MAKER_ID[7:0];
         OCR_ADDR_MAKER_HI: read_nxt = MAKER_ID[15:8];
         OCR_ADDR_PART_LO: read_nxt = PART_ID[7:0];
         OCR_ADDR_PART_HI: read_nxt = PART_ID[15:8];
         OCR_ADDR_CR1_SET, OCR_ADDR_CR1_CLR: read_nxt = ctrl_r[OCR_SLOT_LINE];
         OCR_ADDR_CR2_SET, OCR_ADDR_CR2_CLR: read_nxt = ctrl_r[OCR_SLOT_PULL];
         default: read_nxt = OCR_READ_NONE;
      endcase
   end

   // Read data is captured on the strobe and held until the next read
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= OCR_READ_NONE;
      end else if (reg_rd_i) begin
         reg_rdata_o <= read_nxt;
      end
   end

   // One-cycle answer marker
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
      end
   end

   // ***************************************************************
   // Field outputs
   // ***************************************************************
   // Straight from the control flip-flops, no extra delay
   assign line_control_o = ctrl_r[OCR_SLOT_LINE];
   assign line_rate_full_o = ctrl_r[OCR_SLOT_LINE][OCR_LINE_RATE_BIT];
   assign line_suspend_o = ctrl_r[OCR_SLOT_LINE][OCR_LINE_POWER_BIT];
   assign line_encoding_select_o = ctrl_r[OCR_SLOT_LINE][OCR_LINE_ENC_BIT];
   assign plus_line_pullup_o = ctrl_r[OCR_SLOT_PULL][OCR_PLUS_PULLUP_BIT];
   assign minus_line_pullup_o = ctrl_r[OCR_SLOT_PULL][OCR_MINUS_PULLUP_BIT];
   assign plus_line_pulldown_o = ctrl_r[OCR_SLOT_PULL][OCR_PLUS_PULLDOWN_BIT];
   assign minus_line_pulldown_o = ctrl_r[OCR_SLOT_PULL][OCR_MINUS_PULLDOWN_BIT];
   assign identification_pin_ground_o = ctrl_r[OCR_SLOT_PULL][OCR_ID_GROUND_BIT];
   assign bus_power_drive_o = ctrl_r[OCR_SLOT_PULL][OCR_BUS_DRIVE_BIT];
   assign bus_power_discharge_o = ctrl_r[OCR_SLOT_PULL][OCR_BUS_DISCHARGE_BIT];
   assign bus_power_charge_o = ctrl_r[OCR_SLOT_PULL][OCR_BUS_CHARGE_BIT];

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_set_line;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_SET)
      |=> line_control_o == ($past(line_control_o) | $past(reg_wdata_i));
   endproperty
   a_set_line: assert property (p_set_line) else $error("set write missed");

   property p_clear_pull;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR2_CLR)
      |=> ctrl_r[OCR_SLOT_PULL] == ($past(ctrl_r[OCR_SLOT_PULL]) & ~$past(reg_wdata_i));
   endproperty
   a_clear_pull: assert property (p_clear_pull) else $error("clear write missed");

   property p_read_pair;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && ((reg_addr_i == OCR_ADDR_CR1_SET) || (reg_addr_i == OCR_ADDR_CR1_CLR))
      |=> reg_rvalid_o && (reg_rdata_o == $past(line_control_o));
   endproperty
   a_read_pair: assert property (p_read_pair) else $error("paired read wrong");

   property p_keep_zero_bits;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_CLR)
      |=> (line_control_o & ~$past(reg_wdata_i))
          == ($past(line_control_o) & ~$past(reg_wdata_i));
   endproperty
   a_keep_zero_bits: assert property (p_keep_zero_bits) else $error("zero bit moved");

   property p_maker_id;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && (reg_addr_i == OCR_ADDR_MAKER_HI) ##1 reg_rd_i && (reg_addr_i == OCR_ADDR_MAKER_LO)
      |=> {$past(reg_rdata_o), reg_rdata_o} == MAKER_ID;
   endproperty
   a_maker_id: assert property (p_maker_id) else $error("maker identity wrong");

   property p_part_id;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && (reg_addr_i == OCR_ADDR_PART_LO) ##1 reg_rd_i && (reg_addr_i == OCR_ADDR_PART_HI)
      |=> {reg_rdata_o, $past(reg_rdata_o)} == PART_ID;
   endproperty
   a_part_id: assert property (p_part_id) else $error("part identity wrong");

   property p_rate_full;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_SET) && reg_wdata_i[OCR_LINE_RATE_BIT]
      |=> line_rate_full_o;
   endproperty
   a_rate_full: assert property (p_rate_full) else $error("full speed not taken");

   property p_leave_suspend;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_CLR) && reg_wdata_i[OCR_LINE_POWER_BIT]
      |=> !line_suspend_o;
   endproperty
   a_leave_suspend: assert property (p_leave_suspend) else $error("suspend not cleared");

   property p_encoding;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_SET) && reg_wdata_i[OCR_LINE_ENC_BIT]
      |=> line_encoding_select_o;
   endproperty
   a_encoding: assert property (p_encoding) else $error("encoding not set");

   property p_charge;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR2_SET) && reg_wdata_i[OCR_BUS_CHARGE_BIT]
      |=> bus_power_charge_o && $stable(line_control_o);
   endproperty
   a_charge: assert property (p_charge) else $error("charge bit not set");

   property p_hold_idle;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !reg_wr_i |=> $stable(line_control_o) && $stable(ctrl_r[OCR_SLOT_PULL]);
   endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("control changed idle");

   property p_unmapped;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && (reg_addr_i > OCR_ADDR_CR2_CLR) |=> reg_rdata_o == OCR_READ_NONE;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_set_pull;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR2_SET)
      |=> ctrl_r[OCR_SLOT_PULL] == ($past(ctrl_r[OCR_SLOT_PULL]) | $past(reg_wdata_i));
   endproperty
   a_set_pull: assert property (p_set_pull) else $error("pull set write missed");

   property p_clear_line;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_CLR)
      |=> line_control_o == ($past(line_control_o) & ~$past(reg_wdata_i));
   endproperty
   a_clear_line: assert property (p_clear_line) else $error("line clear write missed");

   property p_read_pull_pair;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && ((reg_addr_i == OCR_ADDR_CR2_SET) || (reg_addr_i == OCR_ADDR_CR2_CLR))
      |=> reg_rvalid_o && (reg_rdata_o == $past(ctrl_r[OCR_SLOT_PULL]));
   endproperty
   a_read_pull_pair: assert property (p_read_pull_pair) else $error("pull read wrong");

   property p_rvalid_pulse;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !reg_rd_i |=> !reg_rvalid_o;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("answer marker without read");

   property p_id_write_ignored;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i <= OCR_ADDR_PART_HI)
      |=> $stable(line_control_o) && $stable(ctrl_r[OCR_SLOT_PULL]);
   endproperty
   a_id_write_ignored: assert property (p_id_write_ignored) else $error("identity write acted");

   property p_maker_lo_read;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && (reg_addr_i == OCR_ADDR_MAKER_LO)
      |=> reg_rdata_o == MAKER_ID[7:0];
   endproperty
   a_maker_lo_read: assert property (p_maker_lo_read) else $error("maker low byte wrong");

   property p_part_hi_read;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && (reg_addr_i == OCR_ADDR_PART_HI)
      |=> reg_rdata_o == PART_ID[15:8];
   endproperty
   a_part_hi_read: assert property (p_part_hi_read) else $error("part high byte wrong");

   property p_rate_low;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_CLR) && reg_wdata_i[OCR_LINE_RATE_BIT]
      |=> !line_rate_full_o;
   endproperty
   a_rate_low: assert property (p_rate_low) else $error("low speed not taken");

   property p_enter_suspend;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_SET) && reg_wdata_i[OCR_LINE_POWER_BIT]
      |=> line_suspend_o;
   endproperty
   a_enter_suspend: assert property (p_enter_suspend) else $error("suspend not set");

   property p_split_line;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR1_CLR) && reg_wdata_i[OCR_LINE_ENC_BIT]
      |=> !line_encoding_select_o;
   endproperty
   a_split_line: assert property (p_split_line) else $error("split line not taken");

   property p_pullup_clear;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_wr_i && (reg_addr_i == OCR_ADDR_CR2_CLR) && reg_wdata_i[OCR_PLUS_PULLUP_BIT]
      |=> !plus_line_pullup_o;
   endproperty
   a_pullup_clear: assert property (p_pullup_clear) else $error("pull-up not cleared");

endmodule : ocr_otg_phy_control_registers

`default_nettype wire

/* ocr_host_model.sv */
/*
 * Host model: byte register master standing in for the serial front end.
 * Assumes one clock; strobes change only just after a rising edge.
 */
`timescale 1ns/10ps
`default_nettype none

module ocr_host_model (
   // Clock
   input wire logic clk_sys_i,
   // Access strobes towards the bank
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_rd_o,
   // Read answer
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   // Idle state at time zero
   initial begin
      reg_addr_o = 8'h5a;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'ha5;
      reg_rd_o = 1'b0;
   end

   // One-cycle write strobe; stale data is inverted so it never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
      reg_addr_o <= ~a;
   endtask : wr

   // One-cycle read strobe; answer taken once settled in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk_sys_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      ok = reg_rvalid_i;
      d = reg_rdata_i;
   endtask : rd
endmodule : ocr_host_model

`default_nettype wire

/* test_otg_phy_control_registers.sv */
/*
 * Self-checking bench of the transceiver control register bank.
 * Assumes the package, the bank and the host model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module test_otg_phy_control_registers;
   import ocr_pkg::*;
   // ***************************************************************
   // Signals and table
   // ***************************************************************
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} ocr_row_s;
   localparam logic [15:0] MK = 16'h5a6b; // Arbitrary value
   localparam logic [15:0] PT = 16'h7c8d; // Arbitrary value
   logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, ok;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv, line_control_o;
   logic line_rate_full_o, line_suspend_o, line_encoding_select_o;
   wire logic [7:0] pulls;
   int err_count = 0;
   int comparisons = 0;
   ocr_row_s rows [0:18];

   ocr_otg_phy_control_registers #(.MAKER_ID(MK), .PART_ID(PT)) dut_u (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .line_rate_full_o(line_rate_full_o), .line_suspend_o(line_suspend_o),
      .line_encoding_select_o(line_encoding_select_o), .line_control_o(line_control_o),
      .plus_line_pullup_o(pulls[0]), .minus_line_pullup_o(pulls[1]),
      .plus_line_pulldown_o(pulls[2]), .minus_line_pulldown_o(pulls[3]),
      .identification_pin_ground_o(pulls[4]), .bus_power_drive_o(pulls[5]),
      .bus_power_discharge_o(pulls[6]), .bus_power_charge_o(pulls[7]));

   ocr_host_model host_u (
      .clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
      .reg_rvalid_i(reg_rvalid_o));

   // 250 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // ***************************************************************
   // Checking and closing
   // ***************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results

   // Watchdog, far beyond the 56 or so cycles the run needs
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      results();
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      // Reads carry the expected byte in d; bank starts from reset values
      rows = '{'{1'b0, 8'h00, MK[7:0]}, '{1'b0, 8'h01, MK[15:8]}, '{1'b0, 8'h02, PT[7:0]},
         '{1'b0, 8'h03, PT[15:8]}, '{1'b1, 8'h04, 8'h05}, '{1'b0, 8'h05, 8'h05},
         '{1'b1, 8'h04, 8'h02}, '{1'b0, 8'h04, 8'h07}, '{1'b1, 8'h05, 8'h04},
         '{1'b0, 8'h04, 8'h03}, '{1'b0, 8'h05, 8'h03}, '{1'b1, 8'h06, 8'ha5},
         '{1'b0, 8'h07, 8'ha5}, '{1'b1, 8'h07, 8'h81}, '{1'b0, 8'h06, 8'h24},
         '{1'b1, 8'h00, 8'hff}, '{1'b0, 8'h00, MK[7:0]}, '{1'b0, 8'h08, 8'h00},
         '{1'b0, 8'h07, 8'h24}};
      rst_n_i = 1'b0;
      repeat (4) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      foreach (rows[i]) begin
         if (rows[i].w) begin
            host_u.wr(rows[i].a, rows[i].d);
         end else begin
            host_u.rd(rows[i].a, rv, ok);
            chk({7'h00, ok}, 8'h01, "read answer marker");
            chk(rv, rows[i].d, "table read");
         end
      end
      @(negedge clk_sys_i);
      chk(pulls, 8'h24, "pull outputs");
      $display("table test done");
      // Field outputs of line control, bit by bit
      host_u.wr(OCR_ADDR_CR1_CLR, 8'hff);
      host_u.wr(OCR_ADDR_CR1_SET, 8'h05);
      @(negedge clk_sys_i);
      chk({5'h00, line_encoding_select_o, line_suspend_o, line_rate_full_o}, 8'h05, "enc rate");
      host_u.wr(OCR_ADDR_CR1_SET, 8'h02);
      @(negedge clk_sys_i);
      chk({5'h00, line_encoding_select_o, line_suspend_o, line_rate_full_o}, 8'h07, "suspend");
      chk(line_control_o, 8'h07, "line control");
      $display("field test done");
      // Reset in mid-run returns every control bit to zero
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(negedge clk_sys_i);
      chk(line_control_o, OCR_CTRL_RESET, "line after reset");
      chk(pulls, OCR_CTRL_RESET, "pulls after reset");
      host_u.rd(OCR_ADDR_CR2_SET, rv, ok);
      chk(rv, OCR_CTRL_RESET, "pull read after reset");
      $display("reset test done");
      results();
   end
endmodule : test_otg_phy_control_registers

`default_nettype wire
